//--- shared/drc_defs.svh
/*
 Register subaddresses, field positions, reset values and fixed-point
 constants of the dynamic range control stage.
 Assumes: included by bare name.
*/
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
`define ADDR_ENABLE_A      8'h96
`define ADDR_ENABLE_B      8'h97
`define ADDR_MAIN_ENERGY   8'h98
`define ADDR_MAIN_TIMING   8'h9C
`define ADDR_SUB_ENERGY    8'h9D
`define ADDR_SUB_TIMING    8'hA1
`define BIT_ENABLE         0
`define BIT_POST_VOLUME    1
`define RST_ENABLE         32'h0000_0000
`define RST_ENERGY         64'h0000_883F_007F_77C0
`define RST_TIMING         128'h0000_883F_007F_77C0_0000_0056_003F_FFA8
`define FRAC_BITS          23
`define GAIN_ONE           28'h080_0000
`define LOG_BIAS           32'h0200_0000
`define LOG_FLOOR          32'h0C00_0000
`define EXP_MAX            6'h04
`define EXP_MIN            6'h29
`define CH_SUB             3'h7
`define MASK_EIGHT         8'h7F
`define MASK_SIX           8'h4F
`endif

//--- shared/drc_pkg.sv
/*
 Types shared by the dynamic range control stage.
 Assumes: drc_defs.svh gives the constants.
*/
package drc_pkg;
    typedef logic signed [23:0] sample_t;
    typedef struct packed {
        logic [7:0][23:0] ch;
    } frame_t;
    typedef struct packed {
        logic signed [31:0] lower_threshold;
        logic signed [31:0] upper_threshold;
        logic signed [31:0] lower_offset;
        logic signed [31:0] upper_offset;
        logic signed [27:0] bottom_region_slope;
        logic signed [27:0] middle_region_slope;
        logic signed [27:0] top_region_slope;
    } curve_t;
    typedef struct packed {
        logic [31:0] attack;
        logic [31:0] attack_rest;
        logic [31:0] decay;
        logic [31:0] decay_rest;
    } timing_t;
    typedef enum logic [1:0] {REG_BOTTOM, REG_MIDDLE, REG_TOP} region_t;
endpackage : drc_pkg

//--- hdl/drc_gain_engine.sv
/*
 Gain engine of one compressor instance: log conversion of the level,
 three-region curve, and attack/decay smoothing of the 5.23 gain.
 Assumes: i_step pulses once per sample after the level has settled.
*/
`timescale 1ns/1ps
`include "drc_defs.svh"
module drc_gain_engine (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_ce,
    input  wire logic             i_step,
    input  wire logic             i_enable,
    input  wire logic [23:0]      i_level,
    input  wire drc_pkg::curve_t  i_curve,
    input  wire drc_pkg::timing_t i_timing,
    output logic [27:0]           o_gain
);
    import drc_pkg::*;

    function automatic logic [4:0] msb_pos(input logic [23:0] v);
        msb_pos = 5'h00;
        for (int i = 0; i < 24; i++)
            if (v[i])
                msb_pos = 5'(i);
    endfunction : msb_pos

    logic        [4:0]  msb;
    logic        [23:0] norm;
    logic signed [31:0] atten;
    logic signed [31:0] glog;
    logic signed [63:0] prod;
    logic signed [5:0]  expo;
    logic        [27:0] target;
    logic signed [59:0] delta;
    region_t            region;
    logic        [27:0] gain;
    logic        [27:0] next_gain;

    // Full scale maps to zero attenuation; every quieter level is positive here
    always_comb
    begin
        msb   = msb_pos(i_level);
        norm  = i_level << (5'd23 - msb);
        // Mantissa is subtracted so attenuation falls as the level rises
        atten = (i_level == 24'h0) ? `LOG_FLOOR
              : {4'h0, 5'd23 - msb, 23'h0} - {9'h0, norm[22:0]};
        if (atten <= i_curve.upper_threshold)
        begin
            region = REG_TOP;
            prod = i_curve.top_region_slope * (i_curve.upper_threshold - atten);
            glog = `LOG_BIAS - i_curve.upper_offset + 32'(prod >>> `FRAC_BITS);
        end
        else if (atten <= i_curve.lower_threshold)
        begin
            region = REG_MIDDLE;
            prod = i_curve.middle_region_slope * (i_curve.upper_threshold - atten);
            glog = `LOG_BIAS - i_curve.upper_offset + 32'(prod >>> `FRAC_BITS);
        end
        else
        begin
            region = REG_BOTTOM;
            prod = i_curve.bottom_region_slope * (i_curve.lower_threshold - atten);
            glog = `LOG_BIAS - i_curve.lower_offset + 32'(prod >>> `FRAC_BITS);
        end
        // Log2 to linear: exact powers of two, linear between them; clamped to 5.23
        expo = 6'(glog >>> `FRAC_BITS);
        if (expo > $signed(`EXP_MAX))
            target = 28'hFFF_FFFF >> 1;
        else if (expo < $signed(`EXP_MIN))
            target = 28'h0;
        else if (expo >= 0)
            target = {4'h0, 1'b1, glog[22:0]} << expo;
        else
            target = {4'h0, 1'b1, glog[22:0]} >> (-expo);
        if (!i_enable)
            target = `GAIN_ONE;
        // Cuts follow the attack constant, boosts the decay constant
        delta = $signed({1'b0, target}) - $signed({1'b0, gain});
        delta = delta * $signed({1'b0, (target < gain) ? i_timing.attack : i_timing.decay});
        next_gain = gain;
        if (i_step)
            next_gain = gain + 28'(delta >>> `FRAC_BITS);
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            gain <= `GAIN_ONE;
        else if (i_ce)
            gain <= next_gain;
    end
    assign o_gain = gain;

    property p_full_scale;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_level == 24'h80_0000) |-> (atten == 32'h0);
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("full scale not 0");

    property p_low_region;
        @(posedge i_clk) disable iff (!i_rstn)
        (atten > i_curve.lower_threshold && atten > i_curve.upper_threshold)
            |-> (region == REG_BOTTOM);
    endproperty
    a_low_region: assert property (p_low_region) else $error("bad region");

    property p_pivot;
        @(posedge i_clk) disable iff (!i_rstn)
        (atten == i_curve.upper_threshold) |-> (glog == `LOG_BIAS - i_curve.upper_offset);
    endproperty
    a_pivot: assert property (p_pivot) else $error("pivot gain wrong");

    property p_flat_slope;
        @(posedge i_clk) disable iff (!i_rstn)
        (region == REG_TOP && i_curve.top_region_slope == 28'sh0)
            |-> (glog == `LOG_BIAS - i_curve.upper_offset);
    endproperty
    a_flat_slope: assert property (p_flat_slope) else $error("slope ignored");
endmodule : drc_gain_engine

//--- hdl/dynamic_range_control.sv
/*
 Dynamic range control stage: per-channel level estimators, a shared
 main compressor and a channel-8 compressor, the gain mixer and a
 two-entry output buffer, plus the subaddress register file.
 Assumes: frames arrive with valid/ready on i_clk; register writes come
 from the host's subaddress decoder as full-width words.
// Notes on behaviour
// - Each level sample yields a 5.23 gain that multiplies the audio stream.
// - Two thresholds split level into three regions, each with its own slope.
// - Main compressor drives ch1-7 in eight-channel, ch1-4 and 7 in six-channel.
// - Main compressor takes the largest per-channel estimate and applies one gain.
// - Sub-channel compressor estimates and adjusts channel 8 only.
// - Stage input selects the signal before or after volume and loudness.
// - Lower and upper offsets set the gain at their thresholds.
// - Slope sign chooses compression or expansion, magnitude its strength.
// - Full-scale input is 0 dB; quieter levels are negative.
// - The energy constant applies identically to every main estimator.
*/
`timescale 1ns/1ps
`include "drc_defs.svh"
module dynamic_range_control (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_ce,
    input  wire logic              i_eight_channel,
    input  wire drc_pkg::curve_t   i_main_curve,
    input  wire drc_pkg::curve_t   i_sub_curve,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic [127:0]      i_reg_wdata,
    output logic [127:0]           o_reg_rdata,
    output logic                   o_reg_rvalid,
    input  wire logic              i_in_valid,
    input  wire drc_pkg::frame_t   i_pre_volume,
    input  wire drc_pkg::frame_t   i_post_volume,
    output logic                   o_in_ready,
    output logic                   o_out_valid,
    output drc_pkg::frame_t        o_out_frame,
    input  wire logic              i_out_ready
);
    import drc_pkg::*;

    logic [31:0]  enable_a;
    logic [31:0]  enable_b;
    logic [63:0]  main_energy;
    logic [127:0] main_timing;
    logic [63:0]  sub_energy;
    logic [127:0] sub_timing;
    logic [127:0] next_rdata;

    // Register file; widths follow each subaddress
    always_comb
    begin
        next_rdata = 128'h0;
        if (i_reg_addr == `ADDR_ENABLE_A)
            next_rdata = {96'h0, enable_a};
        else if (i_reg_addr == `ADDR_ENABLE_B)
            next_rdata = {96'h0, enable_b};
        else if (i_reg_addr == `ADDR_MAIN_ENERGY)
            next_rdata = {64'h0, main_energy};
        else if (i_reg_addr == `ADDR_MAIN_TIMING)
            next_rdata = main_timing;
        else if (i_reg_addr == `ADDR_SUB_ENERGY)
            next_rdata = {64'h0, sub_energy};
        else if (i_reg_addr == `ADDR_SUB_TIMING)
            next_rdata = sub_timing;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            enable_a     <= `RST_ENABLE;
            enable_b     <= `RST_ENABLE;
            main_energy  <= `RST_ENERGY;
            main_timing  <= `RST_TIMING;
            sub_energy   <= `RST_ENERGY;
            sub_timing   <= `RST_TIMING;
            o_reg_rdata  <= 128'h0;
            o_reg_rvalid <= 1'b0;
        end
        else if (i_ce)
        begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd)
                o_reg_rdata <= next_rdata;
            if (i_reg_wr)
            begin
                if (i_reg_addr == `ADDR_ENABLE_A)
                    enable_a <= i_reg_wdata[31:0];
                else if (i_reg_addr == `ADDR_ENABLE_B)
                    enable_b <= i_reg_wdata[31:0];
                else if (i_reg_addr == `ADDR_MAIN_ENERGY)
                    main_energy <= i_reg_wdata[63:0];
                else if (i_reg_addr == `ADDR_MAIN_TIMING)
                    main_timing <= i_reg_wdata;
                else if (i_reg_addr == `ADDR_SUB_ENERGY)
                    sub_energy <= i_reg_wdata[63:0];
                else if (i_reg_addr == `ADDR_SUB_TIMING)
                    sub_timing <= i_reg_wdata;
            end
        end
    end

    logic         accept;
    logic         step;
    frame_t       src;
    logic [7:0]   mask;
    logic [7:0][23:0] level;
    logic [7:0][23:0] next_level;
    logic [23:0]  main_peak;
    logic [27:0]  main_gain;
    logic [27:0]  sub_gain;
    frame_t       mixed;

    assign accept = i_in_valid && o_in_ready;
    assign src    = enable_a[`BIT_POST_VOLUME] ? i_post_volume : i_pre_volume;
    assign mask   = i_eight_channel ? `MASK_EIGHT : `MASK_SIX;

    // Smoothed magnitude per channel; one energy constant per instance
    generate
        for (genvar c = 0; c < 8; c++)
        begin : g_est
            logic        [23:0] mag;
            logic signed [24:0] diff;
            logic signed [57:0] upd;
            logic        [31:0] ae;
            always_comb
            begin
                mag  = src.ch[c][23] ? 24'(-$signed(src.ch[c])) : src.ch[c];
                ae   = (c == 7) ? sub_energy[63:32] : main_energy[63:32];
                diff = $signed({1'b0, mag}) - $signed({1'b0, level[c]});
                upd  = diff * $signed({1'b0, ae});
                next_level[c] = accept ? 24'(level[c] + 24'(upd >>> `FRAC_BITS))
                                       : level[c];
            end
        end
    endgenerate

    // Loudest controlled channel drives the shared gain
    always_comb
    begin
        main_peak = 24'h0;
        for (int c = 0; c < 7; c++)
            if (mask[c] && level[c] > main_peak)
                main_peak = level[c];
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            level <= '0;
            step  <= 1'b0;
        end
        else if (i_ce)
        begin
            level <= next_level;
            step  <= accept;
        end
    end

    drc_gain_engine u_main_compressor (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .i_ce     (i_ce),
        .i_step   (step),
        .i_enable (enable_a[`BIT_ENABLE] && enable_b[`BIT_ENABLE]),
        .i_level  (main_peak),
        .i_curve  (i_main_curve),
        .i_timing (main_timing),
        .o_gain   (main_gain)
    );

    drc_gain_engine u_sub_channel_compressor (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .i_ce     (i_ce),
        .i_step   (step),
        .i_enable (enable_a[`BIT_ENABLE] && enable_b[`BIT_ENABLE]),
        .i_level  (level[`CH_SUB]),
        .i_curve  (i_sub_curve),
        .i_timing (sub_timing),
        .o_gain   (sub_gain)
    );

    // Mixer: controlled samples times 5.23 gain, saturated back to 24 bits; unmasked ones pass unchanged
    generate
        for (genvar c = 0; c < 8; c++)
        begin : g_mix
            logic signed [52:0] p;
            logic signed [29:0] s;
            always_comb
            begin
                p = $signed(src.ch[c]) * $signed({1'b0, (c == 7) ? sub_gain : main_gain});
                s = 30'(p >>> `FRAC_BITS);
                if (c != 7 && !mask[c])
                    mixed.ch[c] = src.ch[c];
                else if (s > 30'sh7F_FFFF)
                    mixed.ch[c] = 24'h7F_FFFF;
                else if (s < -30'sh80_0000)
                    mixed.ch[c] = 24'h80_0000;
                else
                    mixed.ch[c] = s[23:0];
            end
        end
    endgenerate

    // Two-entry buffer: head drives the outputs, tail catches a word during a stall
    frame_t     tail;
    frame_t     next_head;
    frame_t     next_tail;
    logic [1:0] count;
    logic [1:0] next_count;
    logic       pop;

    always_comb
    begin
        pop        = o_out_valid && i_out_ready;
        next_head  = o_out_frame;
        next_tail  = tail;
        next_count = count;
        if (pop && accept)
        begin
            next_head = (count == 2'd2) ? tail : mixed;
            next_tail = mixed;
        end
        else if (pop)
        begin
            next_head  = tail;
            next_count = count - 2'd1;
        end
        else if (accept)
        begin
            if (count == 2'd0)
                next_head = mixed;
            else
                next_tail = mixed;
            next_count = count + 2'd1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_out_frame <= '0;
            tail        <= '0;
            count       <= 2'd0;
            o_out_valid <= 1'b0;
            o_in_ready  <= 1'b0;
        end
        else if (i_ce)
        begin
            o_out_frame <= next_head;
            tail        <= next_tail;
            count       <= next_count;
            o_out_valid <= next_count != 2'd0;
            o_in_ready  <= next_count != 2'd2;
        end
    end

    property p_unity_mix;
        @(posedge i_clk) disable iff (!i_rstn)
        (accept && main_gain == `GAIN_ONE) |-> (mixed.ch[0] == src.ch[0]);
    endproperty
    a_unity_mix: assert property (p_unity_mix) else $error("unity gain altered ch1");

    property p_six_skip;
        @(posedge i_clk) disable iff (!i_rstn)
        (accept && !i_eight_channel) |-> (mixed.ch[4] == src.ch[4] && mixed.ch[5] == src.ch[5]);
    endproperty
    a_six_skip: assert property (p_six_skip) else $error("ch5/6 touched in six mode");

    property p_peak;
        @(posedge i_clk) disable iff (!i_rstn)
        (mask[2]) |-> (main_peak >= level[2] && main_peak >= level[0]);
    endproperty
    a_peak: assert property (p_peak) else $error("peak below a channel");

    property p_sub_alone;
        @(posedge i_clk) disable iff (!i_rstn)
        (accept && sub_gain == `GAIN_ONE) |-> (mixed.ch[7] == src.ch[7]);
    endproperty
    a_sub_alone: assert property (p_sub_alone) else $error("ch8 altered at unity");

    property p_source;
        @(posedge i_clk) disable iff (!i_rstn)
        enable_a[`BIT_POST_VOLUME] |-> (src == i_post_volume);
    endproperty
    a_source: assert property (p_source) else $error("wrong stage input");

    property p_same_energy;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && accept && level[0] == level[1] && src.ch[0] == src.ch[1])
            |=> (level[0] == level[1]);
    endproperty
    a_same_energy: assert property (p_same_energy) else $error("estimators diverge");

    c_stall: cover property (@(posedge i_clk) disable iff (!i_rstn) count == 2'd2);
    c_six:   cover property (@(posedge i_clk) disable iff (!i_rstn) accept && !i_eight_channel);
    c_cut:   cover property (@(posedge i_clk) disable iff (!i_rstn) main_gain < `GAIN_ONE);
endmodule : dynamic_range_control

//--- tb/drc_host_model.sv
/*
 Host model: programs the stage subaddresses with one-cycle strobes.
 Assumes: strobes launched on the falling edge of i_clk.
*/
`timescale 1ns/1ps
`include "drc_defs.svh"
module drc_host_model #(
    parameter int GAP = 40
) (
    input  wire logic         i_clk,
    input  wire logic [127:0] i_reg_rdata,
    input  wire logic         i_reg_rvalid,
    output logic              o_reg_wr,
    output logic              o_reg_rd,
    output logic [7:0]        o_reg_addr,
    output logic [127:0]      o_reg_wdata
);
    localparam logic [31:0] ONE = 32'h0080_0000;
    initial
    begin
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_addr  = 8'h00;
        o_reg_wdata = '0;
    end
    // Released lines show the inverse so a stale value is never mistaken for data
    task wr(input logic [7:0] a, input logic [127:0] d);
        @(negedge i_clk);
        o_reg_addr  = a;
        o_reg_wdata = d;
        o_reg_wr    = 1'b1;
        @(negedge i_clk);
        o_reg_wr    = 1'b0;
        o_reg_addr  = ~a;
        o_reg_wdata = ~d;
    endtask : wr
    task rd(input logic [7:0] a, output logic [127:0] d, output logic ok);
        @(negedge i_clk);
        o_reg_addr = a;
        o_reg_rd   = 1'b1;
        @(negedge i_clk);
        o_reg_rd   = 1'b0;
        o_reg_addr = ~a;
        ok         = i_reg_rvalid;
        d          = i_reg_rdata;
    endtask : rd
    task load_recommended();
        wr(`ADDR_MAIN_TIMING, 128'h0000_883F_007F_77C0_0001_538F_007E_AC70);
        wr(`ADDR_SUB_TIMING, 128'h0000_883F_007F_77C0_0001_538F_007E_AC70);
    endtask : load_recommended
    // Instant time constants keep every gain change inside one frame
    task load_custom();
        wr(`ADDR_MAIN_ENERGY, {64'h0, ONE, 32'h0});
        wr(`ADDR_SUB_ENERGY, {64'h0, ONE, 32'h0});
        wr(`ADDR_MAIN_TIMING, {ONE, 32'h0, ONE, 32'h0});
        wr(`ADDR_SUB_TIMING, {ONE, 32'h0, ONE, 32'h0});
    endtask : load_custom
    // Gap shortened from the real settling time to keep the run short
    task enable(input logic post);
        wr(`ADDR_ENABLE_A, {126'h0, post, 1'b1});
        repeat (GAP) @(negedge i_clk);
        wr(`ADDR_ENABLE_B, 128'h1);
    endtask : enable
endmodule : drc_host_model

//--- tb/dynamic_range_control_bench.sv
/*
 Self-checking bench of the dynamic range control stage.
 Assumes: unity gain passes samples unchanged, gain 0.5 halves even ones.
*/
`timescale 1ns/1ps
`include "drc_defs.svh"
module dynamic_range_control_bench;
    import drc_pkg::*;
    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         ce = 1'b1;
    logic         eight = 1'b1;
    curve_t       main_curve;
    curve_t       sub_curve;
    logic         reg_wr, reg_rd, rvalid, ok;
    logic [7:0]   reg_addr;
    logic [127:0] reg_wdata, rdata, d;
    logic         in_valid = 1'b0;
    frame_t       pre, post, out_frame, f;
    frame_t       burst[8];
    logic         in_ready, out_valid;
    logic         out_ready = 1'b1;
    logic [31:0]  seed = 32'h0000_002E;
    int           n_fail = 0;
    int           n_compared = 0;
    frame_t       out_q[$];
    logic [7:0]   addrs[7] = '{`ADDR_ENABLE_A, `ADDR_ENABLE_B, `ADDR_MAIN_ENERGY,
                               `ADDR_MAIN_TIMING, `ADDR_SUB_ENERGY, `ADDR_SUB_TIMING, 8'h55};
    logic [127:0] rstv[7] = '{128'h0, 128'h0, {64'h0, `RST_ENERGY}, `RST_TIMING,
                              {64'h0, `RST_ENERGY}, `RST_TIMING, 128'h0};

    always #12.5 clk = ~clk;

    dynamic_range_control u_dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce),
        .i_eight_channel(eight), .i_main_curve(main_curve), .i_sub_curve(sub_curve),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_in_valid(in_valid), .i_pre_volume(pre), .i_post_volume(post),
        .o_in_ready(in_ready), .o_out_valid(out_valid), .o_out_frame(out_frame),
        .i_out_ready(out_ready));
    drc_host_model #(.GAP(40)) u_host (.i_clk(clk), .i_reg_rdata(rdata),
        .i_reg_rvalid(rvalid), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
        .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));

    always @(posedge clk)
        if (out_valid === 1'b1 && out_ready === 1'b1)
            out_q.push_back(out_frame);

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [23:0] quiet();
        logic [31:0] r;
        r = xs();
        return {{9{r[15]}}, r[14:1], 1'b0};
    endfunction : quiet
    function automatic logic [23:0] loud();
        logic [31:0] r;
        logic [23:0] m;
        r = xs();
        m = {2'b01, r[21:1], 1'b0};
        return r[31] ? 24'(0 - m) : m;
    endfunction : loud
    // Thresholds are attenuation entries: positive entry means a level below full scale
    function automatic curve_t mk_curve(input logic [31:0] lo_off);
        curve_t c;
        c = '0;
        c.upper_threshold = 32'h0100_0000;
        c.lower_threshold = 32'h0180_0000;
        c.upper_offset    = `LOG_BIAS;
        c.lower_offset    = lo_off;
        return c;
    endfunction : mk_curve
    function automatic frame_t exp_frame(input frame_t x, input logic mh, input logic sh,
                                         input logic e8);
        frame_t r;
        r = x;
        for (int i = 0; i < 8; i++)
            if ((i == 7) ? sh : (mh && (e8 || i < 4 || i == 6)))
                r.ch[i] = {x.ch[i][23], x.ch[i][23:1]};
        return r;
    endfunction : exp_frame
    task check(input logic [191:0] got, input logic [191:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task send(input frame_t a, input frame_t b);
        int k;
        @(negedge clk);
        in_valid = 1'b1;
        pre      = a;
        post     = b;
        for (k = 0; k < 200 && in_ready !== 1'b1; k++)
            @(negedge clk);
        if (k == 200)
            check(192'h0, 192'h1);
        @(negedge clk);
        in_valid = 1'b0;
        pre      = ~a;
        post     = ~b;
    endtask : send
    task drain();
        out_ready = 1'b1;
        repeat (8) @(negedge clk);
    endtask : drain
    task region(input frame_t x, input logic mh, input logic sh, input logic sel);
        out_q.delete();
        repeat (6) send(sel ? ~x : x, sel ? x : ~x);
        drain();
        check(192'(out_q.size()), 192'd6);
        check(out_q[$], exp_frame(x, mh, sh, eight));
    endtask : region
    task end_of_test();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    initial
    begin
        #(25ns * 40000);
        n_fail++;
        end_of_test();
    end

    initial
    begin
        pre        = '0;
        post       = '0;
        main_curve = mk_curve(`LOG_BIAS);
        sub_curve  = mk_curve(`LOG_BIAS);
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            u_host.rd(addrs[i], d, ok);
            check({63'h0, ok, d}, {64'h1, rstv[i]});
        end
        @(negedge clk);
        ce = 1'b0;
        u_host.wr(`ADDR_ENABLE_B, 128'h1);
        ce = 1'b1;
        u_host.wr(8'h55, '1);
        u_host.rd(`ADDR_ENABLE_B, d, ok);
        check({64'h0, d}, 192'h0);
        u_host.rd(8'h55, d, ok);
        check({64'h0, d}, 192'h0);
        u_host.load_recommended();
        u_host.rd(`ADDR_SUB_TIMING, d, ok);
        check({64'h0, d}, {64'h0, 128'h0000_883F_007F_77C0_0001_538F_007E_AC70});
        u_host.load_custom();
        u_host.enable(1'b0);
        for (int i = 0; i < 8; i++)
            f.ch[i] = (i[0]) ? loud() : quiet();
        region(f, 1'b0, 1'b0, 1'b0);
        u_host.wr(`ADDR_ENABLE_A, 128'h3);
        region(f, 1'b0, 1'b0, 1'b1);
        u_host.wr(`ADDR_ENABLE_A, 128'h1);
        main_curve = mk_curve(32'h0280_0000);
        sub_curve  = mk_curve(32'h0280_0000);
        for (int n = 0; n < 6; n++)
        begin
            int idx;
            eight = n[0];
            for (int i = 0; i < 8; i++)
                f.ch[i] = quiet();
            region(f, 1'b1, 1'b1, 1'b0);
            idx = xs() % 7;
            f.ch[idx] = loud();
            region(f, !eight && (idx == 4 || idx == 5), 1'b1, 1'b0);
            f.ch[7] = loud();
            region(f, !eight && (idx == 4 || idx == 5), 1'b0, 1'b0);
        end
        u_host.wr(`ADDR_ENABLE_B, 128'h0);
        region(f, 1'b0, 1'b0, 1'b0);
        u_host.wr(`ADDR_ENABLE_B, 128'h1);
        main_curve = mk_curve(`LOG_BIAS);
        sub_curve  = mk_curve(`LOG_BIAS);
        drain();
        for (int i = 0; i < 8; i++)
            for (int c = 0; c < 8; c++)
                burst[i].ch[c] = loud();
        // Full-scale corner: zero attenuation, and two estimators kept equal
        burst[0].ch[0] = 24'h80_0000;
        burst[0].ch[1] = 24'h80_0000;
        burst[1].ch[1] = burst[1].ch[0];
        out_q.delete();
        out_ready = 1'b0;
        send(burst[0], ~burst[0]);
        send(burst[1], ~burst[1]);
        check({191'h0, in_ready}, 192'h0);
        fork
            for (int i = 2; i < 8; i++)
                send(burst[i], ~burst[i]);
            begin
                repeat (60) @(negedge clk) out_ready = 1'(xs() % 2);
                @(negedge clk) out_ready = 1'b1;
            end
        join
        drain();
        check(192'(out_q.size()), 192'd8);
        for (int i = 0; i < 8; i++)
            check(out_q[i], burst[i]);
        end_of_test();
    end
endmodule : dynamic_range_control_bench
